/* File: src/fcs_pkg.sv */
package fcs_pkg;
    // Bus and counter widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 20;

    // Address map
    localparam logic [15:0] CTRL_ADDR     = 16'h0FFF;
    localparam logic [15:0] FLASH_LO      = 16'h1000;
    localparam logic [15:0] FLASH_HI      = 16'hFFFF;
    localparam logic [15:0] ROM_LO        = 16'h7800;
    localparam logic [15:0] ROM_HI        = 16'h7FFF;
    localparam logic [15:0] WIN_LO        = 16'h8000;
    localparam logic [15:0] LOWER_FLASH_BANK_CPU_LO  = 16'h9000;
    localparam logic [15:0] LOWER_FLASH_BANK_OFFS    = 16'h8000;
    localparam logic [15:0] ID_MAKER_ADDR = 16'hF000;
    localparam logic [15:0] ID_MACRO_ADDR = 16'hF001;
    localparam logic [15:0] ID_SIZE_ADDR  = 16'hF002;
    localparam logic [15:0] SEC_ADDR      = 16'hFF7F;

    // Command cycle low address bits
    localparam logic [11:0] CMD_A1 = 12'h555;
    localparam logic [11:0] CMD_A2 = 12'hAAA;

    // Command data
    localparam logic [7:0] D_UNLOCK1 = 8'hAA;
    localparam logic [7:0] D_UNLOCK2 = 8'h55;
    localparam logic [7:0] D_PROG    = 8'hA0;
    localparam logic [7:0] D_ERASE   = 8'h80;
    localparam logic [7:0] D_SECTOR  = 8'h30;
    localparam logic [7:0] D_CHIP    = 8'h10;
    localparam logic [7:0] D_ID_IN   = 8'h90;
    localparam logic [7:0] D_ID_OUT  = 8'hF0;
    localparam logic [7:0] D_SEC     = 8'hA5;
    localparam logic [7:0] D_SEC_VAL = 8'h00;

    // Read values
    localparam logic [7:0] ERASED_VAL  = 8'hFF;
    localparam logic [7:0] UNMAP_VAL   = 8'hFF;
    localparam logic [7:0] SEC_OFF_VAL = 8'hFF;
    localparam logic [7:0] SEC_ON_VAL  = 8'h00;
    localparam logic [7:0] SIZE_CODE   = 8'h0E;
    localparam logic [7:0] MAKER_CODE  = 8'h5A; // Arbitrary value
    localparam logic [7:0] MACRO_CODE  = 8'h3C; // Arbitrary value
    localparam logic [7:0] ROM_FILL    = 8'h00;

    // Control register layout
    localparam int          KEY_MSB    = 7;
    localparam int          KEY_LSB    = 4;
    localparam int          BANK_BIT   = 3;
    localparam int          TOGGLE_BIT = 6;
    localparam logic [3:0]  KEY_ENABLE = 4'h3;
    localparam logic [3:0]  KEY_LOCK   = 4'hC;
    localparam logic [7:0]  CTRL_RESET = 8'hC0;
    localparam logic [2:0]  CTRL_LOW_RD = 3'h0;

    // Timing
    localparam longint CLK_HZ       = 25_000_000;
    localparam longint PROG_TIME_US = 40;
    localparam longint ERASE_TIME_MS = 30;
    localparam longint PROG_CYCLES  = PROG_TIME_US * CLK_HZ / 1_000_000;
    localparam longint ERASE_CYCLES = ERASE_TIME_MS * CLK_HZ / 1_000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_C1   = 4'h1,
        ST_C2   = 4'h3,
        ST_PROG = 4'h2,
        ST_ER3  = 4'h6,
        ST_ER4  = 4'h7,
        ST_ER5  = 4'h5,
        ST_SEC  = 4'h4,
        ST_BUSY = 4'hC
    } fcs_state_type;

    typedef enum logic [1:0] {
        OP_PROG   = 2'h0,
        OP_SERASE = 2'h1,
        OP_CERASE = 2'h2,
        OP_SEC    = 2'h3
    } fcs_op_type;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_SEND = 2'h1,
        HS_WAIT = 2'h3,
        HS_FIX  = 2'h2
    } fcs_hstate_type;
endpackage : fcs_pkg

/* File: src/fcs_bus_if.sv */
`timescale 1ns/100ps
interface fcs_bus_if;
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rvalid;

    modport dev (input req, input we, input addr, input wdata, output rdata, output rvalid);
    modport cpu (output req, output we, output addr, output wdata, input rdata, input rvalid);
endinterface : fcs_bus_if

/* File: src/fcs_sequencer.sv */
// Operation
// [R01] Commands act only with key 0011
// [R02] Reset loads key 1100
// [R03] Software writes only 1100 or 0011
// [R04] CPU mode maps flash at real addresses
// [R05] Boot mode: ROM 7800-7FFF, window above
// [R06] Bank select picks lower/upper flash bank
// [R07] Command cycles compare low 12 bits
// [R08] Byte program is four writes
// [R09] Sector erase is six writes
// [R10] Chip erase ends 555/10, fills FF
// [R11] 555/90 enters identification, returns codes
// [R12] Size code reads 0E
// [R13] FF7F reads FF when not secured
// [R14] F0 write or sequence leaves identification
// [R15] Security sequence sets protection
// [R16] Only chip erase clears protection; sys_rst also clears sec_ff
// [R17] Boot mode: bank 1 before security
// [R18] Busy reads toggle bit 6
// [R19] No new command until done; poll
// [R20] Program 40 us, erase 30 ms
// [R21] Erase before reprogramming
// [R22] Control low three bits undefined
// [R23] First busy read bit 6 is one
// [R24] Mismatching write abandons sequence
`timescale 1ns/100ps
module fcs_sequencer #(
    parameter int ERASE_CYCLES = int'(fcs_pkg::ERASE_CYCLES)
) (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  serial_boot_mode,
    fcs_bus_if.dev     bus,
    output logic       busy,
    output logic       secured,
    output logic       id_mode
);
    localparam logic [19:0] PROG_LOAD  = 20'(fcs_pkg::PROG_CYCLES - 1);
    localparam logic [19:0] ERASE_LOAD = 20'(ERASE_CYCLES - 1);

    fcs_pkg::fcs_state_type state_ff, nxt_state;
    fcs_pkg::fcs_op_type    op_ff,    nxt_op;
    logic [19:0]            cnt_ff,   nxt_cnt;
    logic [3:0]             key_ff,   nxt_key;
    logic                   bank_ff,  nxt_bank;
    logic                   sec_ff,   nxt_sec;
    logic                   id_ff,    nxt_id;
    logic                   tog_ff,   nxt_tog;
    logic [15:0]            tgt_ff,   nxt_tgt;
    logic [7:0]             dat_ff,   nxt_dat;
    logic [7:0]             rdata_ff, nxt_rdata;
    logic                   rvalid_ff;
    logic [7:0]             mem_ff [fcs_pkg::FLASH_LO:fcs_pkg::FLASH_HI];

    logic [16:0] map;
    logic        fl_hit;
    logic [15:0] fa;
    logic        rom_hit;
    logic        ctrl_hit;
    logic [11:0] lo;
    logic [7:0]  d;
    logic        wr;
    logic        done, key_ok;

    // Cpu address to flash address, bit 16 flags a hit
    function automatic logic [16:0] fcs_map(input logic [15:0] a, input logic ser,
                                            input logic bank);
        logic [16:0] r;
        r = '0;
        if (!ser)
        begin
            if (a >= fcs_pkg::FLASH_LO)
                r = {1'b1, a}; // R04
        end
        else if (a >= fcs_pkg::WIN_LO)
        begin
            if (bank)
                r = {1'b1, a}; // R06
            else if (a >= fcs_pkg::LOWER_FLASH_BANK_CPU_LO)
                r = {1'b1, a - fcs_pkg::LOWER_FLASH_BANK_OFFS}; // R06
        end
        return r;
    endfunction : fcs_map

    assign map      = fcs_map(bus.addr, serial_boot_mode, bank_ff);
    assign fl_hit   = map[16];
    assign fa       = map[15:0];
    assign rom_hit  = serial_boot_mode && bus.addr >= fcs_pkg::ROM_LO
                      && bus.addr <= fcs_pkg::ROM_HI; // R05
    assign ctrl_hit = bus.addr == fcs_pkg::CTRL_ADDR;
    assign lo       = bus.addr[11:0];
    assign d        = bus.wdata;
    assign wr       = bus.req && bus.we;
    assign key_ok   = key_ff == fcs_pkg::KEY_ENABLE; // R01
    assign done     = state_ff == fcs_pkg::ST_BUSY && cnt_ff == '0;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_op    = op_ff;
        nxt_cnt   = cnt_ff;
        nxt_key   = key_ff;
        nxt_bank  = bank_ff;
        nxt_sec   = sec_ff;
        nxt_id    = id_ff;
        nxt_tog   = tog_ff;
        nxt_tgt   = tgt_ff;
        nxt_dat   = dat_ff;
        if (state_ff == fcs_pkg::ST_BUSY)
        begin
            nxt_cnt = cnt_ff - 20'h1;
            if (done)
            begin
                nxt_state = fcs_pkg::ST_IDLE; // R20
                if (op_ff == fcs_pkg::OP_SEC)
                    nxt_sec = 1'b1; // R15
                else if (op_ff == fcs_pkg::OP_CERASE)
                    nxt_sec = 1'b0; // R16
            end
        end
        if (wr && ctrl_hit)
        begin
            nxt_key  = d[fcs_pkg::KEY_MSB:fcs_pkg::KEY_LSB];
            nxt_bank = d[fcs_pkg::BANK_BIT];
        end
        else if (wr && fl_hit && key_ok && state_ff != fcs_pkg::ST_BUSY) // R01 R19
        begin
            nxt_state = fcs_pkg::ST_IDLE; // R24
            if (d == fcs_pkg::D_ID_OUT)
                nxt_id = 1'b0; // R14
            else
            begin
                case (state_ff)
                    fcs_pkg::ST_IDLE:
                        if (lo == fcs_pkg::CMD_A1 && d == fcs_pkg::D_UNLOCK1) // R07
                            nxt_state = fcs_pkg::ST_C1;
                    fcs_pkg::ST_C1:
                        if (lo == fcs_pkg::CMD_A2 && d == fcs_pkg::D_UNLOCK2)
                            nxt_state = fcs_pkg::ST_C2;
                    fcs_pkg::ST_C2:
                        if (lo == fcs_pkg::CMD_A1)
                        begin
                            case (d)
                                fcs_pkg::D_PROG:  nxt_state = fcs_pkg::ST_PROG; // R08
                                fcs_pkg::D_ERASE: nxt_state = fcs_pkg::ST_ER3; // R09
                                fcs_pkg::D_SEC:   nxt_state = fcs_pkg::ST_SEC; // R15
                                fcs_pkg::D_ID_IN: nxt_id = 1'b1; // R11
                                default:          nxt_state = fcs_pkg::ST_IDLE;
                            endcase
                        end
                    fcs_pkg::ST_PROG:
                        if (!(serial_boot_mode && sec_ff)) // R15
                        begin
                            nxt_state = fcs_pkg::ST_BUSY; // R08
                            nxt_op    = fcs_pkg::OP_PROG;
                            nxt_cnt   = PROG_LOAD; // R20
                            nxt_tgt   = fa;
                            nxt_dat   = d;
                            nxt_tog   = 1'b1; // R23
                        end
                    fcs_pkg::ST_ER3:
                        if (lo == fcs_pkg::CMD_A1 && d == fcs_pkg::D_UNLOCK1)
                            nxt_state = fcs_pkg::ST_ER4;
                    fcs_pkg::ST_ER4:
                        if (lo == fcs_pkg::CMD_A2 && d == fcs_pkg::D_UNLOCK2)
                            nxt_state = fcs_pkg::ST_ER5;
                    fcs_pkg::ST_ER5:
                        if (d == fcs_pkg::D_SECTOR)
                        begin
                            nxt_state = fcs_pkg::ST_BUSY; // R09
                            nxt_op    = fcs_pkg::OP_SERASE;
                            nxt_cnt   = ERASE_LOAD; // R20
                            nxt_tgt   = fa;
                            nxt_tog   = 1'b1; // R23
                        end
                        else if (lo == fcs_pkg::CMD_A1 && d == fcs_pkg::D_CHIP)
                        begin
                            nxt_state = fcs_pkg::ST_BUSY; // R10
                            nxt_op    = fcs_pkg::OP_CERASE;
                            nxt_cnt   = ERASE_LOAD; // R20
                            nxt_tog   = 1'b1; // R23
                        end
                    fcs_pkg::ST_SEC:
                        if (fa == fcs_pkg::SEC_ADDR && d == fcs_pkg::D_SEC_VAL)
                        begin
                            nxt_state = fcs_pkg::ST_BUSY; // R15
                            nxt_op    = fcs_pkg::OP_SEC;
                            nxt_cnt   = PROG_LOAD; // R20
                            nxt_tog   = 1'b1; // R23
                        end
                    default:
                        nxt_state = fcs_pkg::ST_IDLE;
                endcase
            end
        end
        if (bus.req && !bus.we && fl_hit && state_ff == fcs_pkg::ST_BUSY)
            nxt_tog = ~tog_ff; // R18
    end

    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (bus.req && !bus.we)
        begin
            if (ctrl_hit)
                nxt_rdata = {key_ff, bank_ff, fcs_pkg::CTRL_LOW_RD}; // R22
            else if (fl_hit && state_ff == fcs_pkg::ST_BUSY)
            begin
                nxt_rdata = mem_ff[fa];
                nxt_rdata[fcs_pkg::TOGGLE_BIT] = tog_ff; // R18 R23
            end
            else if (id_ff && bus.addr == fcs_pkg::ID_MAKER_ADDR)
                nxt_rdata = fcs_pkg::MAKER_CODE; // R11
            else if (id_ff && bus.addr == fcs_pkg::ID_MACRO_ADDR)
                nxt_rdata = fcs_pkg::MACRO_CODE; // R11
            else if (id_ff && bus.addr == fcs_pkg::ID_SIZE_ADDR)
                nxt_rdata = fcs_pkg::SIZE_CODE; // R12
            else if (id_ff && bus.addr == fcs_pkg::SEC_ADDR)
                nxt_rdata = sec_ff ? fcs_pkg::SEC_ON_VAL : fcs_pkg::SEC_OFF_VAL; // R13
            else if (rom_hit)
                nxt_rdata = fcs_pkg::ROM_FILL; // R05
            else if (fl_hit)
                nxt_rdata = mem_ff[fa];
            else
                nxt_rdata = fcs_pkg::UNMAP_VAL;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_ff  <= fcs_pkg::ST_IDLE;
            op_ff     <= fcs_pkg::OP_PROG;
            cnt_ff    <= '0;
            key_ff    <= fcs_pkg::CTRL_RESET[fcs_pkg::KEY_MSB:fcs_pkg::KEY_LSB]; // R02
            bank_ff   <= fcs_pkg::CTRL_RESET[fcs_pkg::BANK_BIT];
            sec_ff    <= 1'b0;
            id_ff     <= 1'b0;
            tog_ff    <= 1'b1;
            tgt_ff    <= '0;
            dat_ff    <= '0;
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            op_ff     <= nxt_op;
            cnt_ff    <= nxt_cnt;
            key_ff    <= nxt_key;
            bank_ff   <= nxt_bank;
            sec_ff    <= nxt_sec;
            id_ff     <= nxt_id;
            tog_ff    <= nxt_tog;
            tgt_ff    <= nxt_tgt;
            dat_ff    <= nxt_dat;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= bus.req && !bus.we;
        end
    end

    // Array is non-volatile, so it has no reset
    always_ff @(posedge clk)
    begin
        if (done)
        begin
            case (op_ff)
                fcs_pkg::OP_PROG:
                    mem_ff[tgt_ff] <= dat_ff; // R08
                fcs_pkg::OP_SERASE:
                    for (int i = int'(fcs_pkg::FLASH_LO); i <= int'(fcs_pkg::FLASH_HI); i++)
                        if (i[15:12] == tgt_ff[15:12])
                            mem_ff[i] <= fcs_pkg::ERASED_VAL; // R09
                fcs_pkg::OP_CERASE:
                    for (int i = int'(fcs_pkg::FLASH_LO); i <= int'(fcs_pkg::FLASH_HI); i++)
                        mem_ff[i] <= fcs_pkg::ERASED_VAL; // R10
                default:
                    ;
            endcase
        end
    end

    assign bus.rdata  = rdata_ff;
    assign bus.rvalid = rvalid_ff;
    assign busy       = state_ff == fcs_pkg::ST_BUSY;
    assign secured    = sec_ff;
    assign id_mode    = id_ff;
endmodule : fcs_sequencer

/* File: src/fcs_cpu.sv */
`timescale 1ns/100ps
module fcs_cpu (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        serial_boot_mode,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_we,
    input  wire logic        cmd_poll,
    input  wire logic [15:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             cmd_ready,
    output logic             resp_valid,
    output logic [7:0]       resp_data,
    fcs_bus_if.cpu           bus
);
    fcs_pkg::fcs_hstate_type st_ff, nxt_st;
    logic        req_ff,   nxt_req;
    logic        we_ff,    nxt_we;
    logic [15:0] addr_ff,  nxt_addr;
    logic [7:0]  wdata_ff, nxt_wdata;
    logic [15:0] paddr_ff, nxt_paddr;
    logic [7:0]  pdata_ff, nxt_pdata;
    logic        pwe_ff,   nxt_pwe;
    logic        poll_ff,  nxt_poll;
    logic [7:0]  shadow_ff, nxt_shadow;
    logic [7:0]  prev_ff,  nxt_prev;
    logic        havep_ff, nxt_havep;
    logic        rv_ff,    nxt_rv;
    logic [7:0]  rd_ff,    nxt_rd;
    logic [7:0]  wd;
    logic        need_fix;

    // Key field forced to one of the two legal values
    always_comb
    begin
        wd = cmd_wdata;
        if (cmd_we && cmd_addr == fcs_pkg::CTRL_ADDR
            && wd[fcs_pkg::KEY_MSB:fcs_pkg::KEY_LSB] != fcs_pkg::KEY_ENABLE)
            wd[fcs_pkg::KEY_MSB:fcs_pkg::KEY_LSB] = fcs_pkg::KEY_LOCK; // R03
    end

    assign need_fix = serial_boot_mode && cmd_we && cmd_addr[11:0] == fcs_pkg::CMD_A1
                      && cmd_wdata == fcs_pkg::D_SEC && !shadow_ff[fcs_pkg::BANK_BIT];

    always_comb
    begin
        nxt_st     = st_ff;
        nxt_req    = 1'b0;
        nxt_we     = we_ff;
        nxt_addr   = addr_ff;
        nxt_wdata  = wdata_ff;
        nxt_paddr  = paddr_ff;
        nxt_pdata  = pdata_ff;
        nxt_pwe    = pwe_ff;
        nxt_poll   = poll_ff;
        nxt_shadow = shadow_ff;
        nxt_prev   = prev_ff;
        nxt_havep  = havep_ff;
        nxt_rv     = 1'b0;
        nxt_rd     = rd_ff;
        case (st_ff)
            fcs_pkg::HS_IDLE:
                if (cmd_valid && cmd_ready)
                begin
                    nxt_paddr = cmd_addr;
                    nxt_pdata = wd;
                    nxt_pwe   = cmd_we;
                    nxt_poll  = cmd_poll && !cmd_we;
                    nxt_havep = 1'b0;
                    nxt_req   = 1'b1;
                    nxt_we    = cmd_we;
                    if (need_fix)
                    begin
                        nxt_st    = fcs_pkg::HS_FIX; // R17
                        nxt_addr  = fcs_pkg::CTRL_ADDR;
                        nxt_wdata = shadow_ff | (8'h01 << fcs_pkg::BANK_BIT);
                        nxt_shadow = nxt_wdata;
                        nxt_we    = 1'b1;
                    end
                    else
                    begin
                        nxt_st    = fcs_pkg::HS_SEND;
                        nxt_addr  = cmd_addr;
                        nxt_wdata = wd;
                        if (cmd_we && cmd_addr == fcs_pkg::CTRL_ADDR)
                            nxt_shadow = wd;
                    end
                end
            fcs_pkg::HS_FIX:
            begin
                nxt_st    = fcs_pkg::HS_SEND;
                nxt_req   = 1'b1;
                nxt_we    = pwe_ff;
                nxt_addr  = paddr_ff;
                nxt_wdata = pdata_ff;
            end
            fcs_pkg::HS_SEND:
                if (we_ff)
                begin
                    nxt_st = fcs_pkg::HS_IDLE;
                    nxt_rv = 1'b1;
                end
                else
                    nxt_st = fcs_pkg::HS_WAIT;
            fcs_pkg::HS_WAIT:
                if (bus.rvalid)
                begin
                    if (poll_ff && (!havep_ff || bus.rdata != prev_ff)) // R19
                    begin
                        nxt_prev  = bus.rdata;
                        nxt_havep = 1'b1;
                        nxt_req   = 1'b1;
                        nxt_st    = fcs_pkg::HS_SEND;
                    end
                    else
                    begin
                        nxt_rd = bus.rdata;
                        nxt_rv = 1'b1;
                        nxt_st = fcs_pkg::HS_IDLE;
                    end
                end
            default:
                nxt_st = fcs_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_ff     <= fcs_pkg::HS_IDLE;
            req_ff    <= 1'b0;
            we_ff     <= 1'b0;
            addr_ff   <= '0;
            wdata_ff  <= '0;
            paddr_ff  <= '0;
            pdata_ff  <= '0;
            pwe_ff    <= 1'b0;
            poll_ff   <= 1'b0;
            shadow_ff <= fcs_pkg::CTRL_RESET;
            prev_ff   <= '0;
            havep_ff  <= 1'b0;
            rv_ff     <= 1'b0;
            rd_ff     <= '0;
            cmd_ready <= 1'b0;
        end
        else
        begin
            st_ff     <= nxt_st;
            req_ff    <= nxt_req;
            we_ff     <= nxt_we;
            addr_ff   <= nxt_addr;
            wdata_ff  <= nxt_wdata;
            paddr_ff  <= nxt_paddr;
            pdata_ff  <= nxt_pdata;
            pwe_ff    <= nxt_pwe;
            poll_ff   <= nxt_poll;
            shadow_ff <= nxt_shadow;
            prev_ff   <= nxt_prev;
            havep_ff  <= nxt_havep;
            rv_ff     <= nxt_rv;
            rd_ff     <= nxt_rd;
            cmd_ready <= nxt_st == fcs_pkg::HS_IDLE;
        end
    end

    assign bus.req    = req_ff;
    assign bus.we     = we_ff;
    assign bus.addr   = addr_ff;
    assign bus.wdata  = wdata_ff;
    assign resp_valid = rv_ff;
    assign resp_data  = rd_ff;
endmodule : fcs_cpu

/* File: tb/fcs_properties.sv */
`timescale 1ns/100ps
module fcs_checker #(
    parameter int ERASE_CYCLES = 50
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        req,
    input wire logic        we,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        rvalid,
    input wire logic        busy,
    input wire logic        secured,
    input wire logic        id_mode
);
    logic        key_ff, nxt_key, arm_ff, nxt_arm, b6_ff, nxt_b6;
    logic [19:0] cnt_ff, nxt_cnt;
    always_comb
    begin
        nxt_key = key_ff;
        if (req && we && addr == fcs_pkg::CTRL_ADDR)
            nxt_key = wdata[7:4] == fcs_pkg::KEY_ENABLE;
        nxt_arm = !busy || (arm_ff && !rvalid);
        nxt_b6  = rvalid ? rdata[6] : b6_ff;
        nxt_cnt = busy ? cnt_ff + 20'h1 : 20'h0;
        if (sys_rst)
        begin
            nxt_key = 1'b0;
            nxt_arm = 1'b1;
        end
    end
    always_ff @(posedge clk)
    begin
        key_ff <= nxt_key;
        arm_ff <= nxt_arm;
        b6_ff  <= nxt_b6;
        cnt_ff <= nxt_cnt;
    end
    default clocking fcs_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_wr(a, d);
        req && we && addr[11:0] == a && wdata == d;
    endsequence
    sequence s_unlock;
        s_wr(12'h555, 8'hAA) ##[2:4] s_wr(12'hAAA, 8'h55);
    endsequence
    AST_READ_ANSWER: assert property (req && !we |=> rvalid)
        else $error("read not answered next cycle");
    AST_ANSWER_CAUSE: assert property (rvalid |-> $past(req && !we))
        else $error("answer without read");
    AST_LOCKED: assert property (!key_ff && !busy |=> !busy && !$rose(id_mode))
        else $error("command acted while locked");
    AST_ID_ENTRY: assert property (key_ff && !busy ##0 s_unlock ##[2:4] s_wr(12'h555, 8'h90)
        |=> id_mode) else $error("identification not entered");
    AST_ID_EXIT: assert property (req && we && wdata == 8'hF0 && addr != fcs_pkg::CTRL_ADDR
        && key_ff && !busy |=> !id_mode) else $error("identification not left");
    AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_ff == 20'h3E8 || cnt_ff == ERASE_CYCLES)
        else $error("operation length wrong");
    AST_SEC_STICKY: assert property ($fell(secured) |-> $fell(busy))
        else $error("protection cleared outside erase");
    AST_FIRST_READ: assert property (busy && rvalid && arm_ff |-> rdata[6])
        else $error("first busy read bit 6 low");
    AST_TOGGLE: assert property (busy && rvalid && !arm_ff |-> rdata[6] != b6_ff)
        else $error("bit 6 did not toggle");
endmodule : fcs_checker

/* File: tb/tb_flash_command_sequencer.sv */
`timescale 1ns/100ps
module tb_flash_command_sequencer;
    logic        clk, sys_rst, serial_boot_mode, cmd_valid, cmd_we, cmd_poll;
    logic        cmd_ready, resp_valid, busy, secured, id_mode;
    logic [15:0] cmd_addr;
    logic [7:0]  cmd_wdata, resp_data, got;
    int          error_cnt, compares;
    fcs_bus_if bus_if ();
    fcs_sequencer #(.ERASE_CYCLES(50)) u_fcs_sequencer (.clk(clk), .sys_rst(sys_rst),
        .serial_boot_mode(serial_boot_mode), .bus(bus_if), .busy(busy), .secured(secured),
        .id_mode(id_mode));
    fcs_cpu u_fcs_cpu (.clk(clk), .sys_rst(sys_rst), .serial_boot_mode(serial_boot_mode),
        .cmd_valid(cmd_valid), .cmd_we(cmd_we), .cmd_poll(cmd_poll), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .bus(bus_if));
    fcs_checker #(.ERASE_CYCLES(50)) u_fcs_checker (.clk(clk), .sys_rst(sys_rst),
        .req(bus_if.req), .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .rvalid(bus_if.rvalid), .busy(busy), .secured(secured),
        .id_mode(id_mode));
    always #20 clk = ~clk;
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] act);
        compares++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, act);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input logic p);
        cmd_we    = w;
        cmd_addr  = a;
        cmd_wdata = d;
        cmd_poll  = p;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1)
            @(posedge clk) #1;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1)
            @(posedge clk) #1;
        got = resp_data;
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr
    task automatic rd(input string n, input logic [15:0] a, input logic p, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, p);
        check(n, e, got);
    endtask : rd
    task automatic unlock(input logic [15:0] a, input logic [7:0] d);
        wr(16'hF555, 8'hAA);
        wr(16'hFAAA, 8'h55);
        wr(a, d);
    endtask : unlock
    task automatic erase(input logic [15:0] a, input logic [7:0] d);
        unlock(16'hF555, 8'h80);
        unlock(a, d);
        check("busy", 8'h01, {7'h0, busy});
        do xfer(1'b0, 16'h1000, 8'h00, 1'b1); while (busy);
    endtask : erase
    task automatic test_setup;
        rd("control", 16'h0FFF, 1'b0, 8'hC0);
        unlock(16'hF555, 8'hA0);
        wr(16'h1234, 8'h00);
        check("locked busy", 8'h00, {7'h0, busy});
        wr(16'h0FFF, 8'h30);
        erase(16'hF555, 8'h10);
        rd("erased", 16'h1234, 1'b1, 8'hFF);
        $display("test setup done");
    endtask : test_setup
    task automatic test_program;
        unlock(16'hF555, 8'hA0);
        wr(16'h1234, 8'h3C);
        xfer(1'b0, 16'h1234, 8'h00, 1'b0);
        check("first bit 6", 8'h01, {7'h0, got[6]});
        xfer(1'b0, 16'h1234, 8'h00, 1'b0);
        check("second bit 6", 8'h00, {7'h0, got[6]});
        rd("programmed", 16'h1234, 1'b1, 8'h3C);
        unlock(16'hF555, 8'hA0);
        wr(16'h2000, 8'h5A);
        rd("programmed 2", 16'h2000, 1'b1, 8'h5A);
        erase(16'h2345, 8'h30);
        rd("sector erased", 16'h2000, 1'b1, 8'hFF);
        rd("sector kept", 16'h1234, 1'b0, 8'h3C);
        wr(16'hF555, 8'hAA);
        wr(16'hF123, 8'h77);
        wr(16'hFAAA, 8'h55);
        wr(16'hF555, 8'hA0);
        wr(16'h3000, 8'h11);
        rd("abandoned", 16'h3000, 1'b1, 8'hFF);
        $display("test program done");
    endtask : test_program
    task automatic test_map;
        wr(16'h0FFF, 8'h38);
        rd("normal map", 16'h1234, 1'b0, 8'h3C);
        serial_boot_mode = 1'b1;
        rd("boot rom", 16'h7800, 1'b0, 8'h00);
        rd("upper bank", 16'h9234, 1'b0, 8'hFF);
        wr(16'h0FFF, 8'h30);
        rd("lower bank", 16'h9234, 1'b0, 8'h3C);
        serial_boot_mode = 1'b0;
        $display("test map done");
    endtask : test_map
    task automatic test_id;
        unlock(16'hF555, 8'h90);
        rd("maker", 16'hF000, 1'b0, fcs_pkg::MAKER_CODE);
        rd("size", 16'hF002, 1'b0, 8'h0E);
        rd("unsecured", 16'hFF7F, 1'b0, 8'hFF);
        wr(16'hF123, 8'hF0);
        rd("left id", 16'hF002, 1'b0, 8'hFF);
        unlock(16'hF555, 8'hA5);
        wr(16'hFF7F, 8'h00);
        xfer(1'b0, 16'h1000, 8'h00, 1'b1);
        check("secured", 8'h01, {7'h0, secured});
        unlock(16'hF555, 8'h90);
        rd("secured id", 16'hFF7F, 1'b0, 8'h00);
        unlock(16'hF555, 8'hF0);
        check("id exit seq", 8'h00, {7'h0, id_mode});
        erase(16'hF555, 8'h10);
        check("cleared", 8'h00, {7'h0, secured});
        $display("test id done");
    endtask : test_id
    initial
    begin
        {clk, sys_rst, serial_boot_mode, cmd_valid, cmd_we, cmd_poll} = 6'b010000;
        {cmd_addr, cmd_wdata, error_cnt, compares} = '0;
        repeat (2) @(posedge clk) #1;
        sys_rst = 1'b0;
        test_setup();
        test_program();
        test_map();
        test_id();
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule : tb_flash_command_sequencer
